// ### verilog/serial_prom_pkg.sv
// Constants shared by the bit-serial EEPROM host controller.
package serial_prom_pkg;
   localparam int CLK_HZ = 25000000;
   localparam int ADDR_BITS = 16;
   localparam int BYTE_BITS = 8;
   localparam int PAGE_BYTES = 32;
   localparam int PAGE_IDX_W = 5;
   localparam int STROBE_NS = 80;
   localparam int STROBE_CYC = (STROBE_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int BUSY_POLL_MAX = 100000;
   localparam logic [7:0] STROBE_CNT = 8'(STROBE_CYC);
   // Extra low cycles on a read so the returned bit passes the pin synchroniser in time.
   localparam logic [7:0] SYNC_CNT = 8'h01;
   localparam logic [4:0] ADDR_LAST = 5'h0f;
   localparam logic [4:0] BIT_LAST = 5'h07;
   localparam logic [4:0] PAGE_LAST = 5'h1f;
   localparam logic [4:0] CNT_ZERO = 5'h00;
   localparam logic [2:0] CMD_READ = 3'h1;
   localparam logic [2:0] CMD_WRITE = 3'h2;
   typedef enum logic [1:0] {
      CYC_RD = 2'b00,
      CYC_WR0 = 2'b01,
      CYC_WR1 = 2'b10
   } cyc_t;
endpackage

// ### verilog/bus_cycle.sv
// One strobe cycle on the memory bus: a read or a one-bit write.
`timescale 1ns/100ps
module bus_cycle (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire serial_prom_pkg::cyc_t kind,
   input wire logic io_sync,
   output logic ce_n,
   output logic oe_n,
   output logic we_n,
   output logic io_out,
   output logic io_oe,
   output logic done,
   output logic rd_bit
);
   import serial_prom_pkg::*;

   logic [7:0] cnt, next_cnt;
   logic busy, next_busy;
   logic next_ce_n, next_oe_n, next_we_n, next_io_out, next_io_oe, next_done, next_rd_bit;

   always_comb begin
      next_cnt = cnt;
      next_busy = busy;
      next_ce_n = ce_n;
      next_oe_n = oe_n;
      next_we_n = we_n;
      next_io_out = io_out;
      next_io_oe = io_oe;
      next_done = 1'b0;
      next_rd_bit = rd_bit;
      // The cycle that reports done never starts another, so the caller's next kind is settled.
      if (!busy && start && !done) begin
         next_busy = 1'b1;
         next_cnt = (kind == CYC_RD) ? STROBE_CNT + SYNC_CNT : STROBE_CNT;
         next_ce_n = 1'b0;
         // Write enable and output enable are never low together.
         next_oe_n = (kind != CYC_RD);
         next_we_n = (kind == CYC_RD);
         next_io_oe = (kind != CYC_RD);
         next_io_out = (kind == CYC_WR1);
      end else if (busy) begin
         if (cnt != 8'h00) begin
            next_cnt = cnt - 8'h01;
         end else begin
            // Strobes rise together; data stays driven through the edge for hold.
            next_busy = 1'b0;
            next_ce_n = 1'b1;
            next_oe_n = 1'b1;
            next_we_n = 1'b1;
            next_done = 1'b1;
            next_rd_bit = io_sync;
         end
      end else begin
         next_io_oe = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 8'h00;
         busy <= 1'b0;
         ce_n <= 1'b1;
         oe_n <= 1'b1;
         we_n <= 1'b1;
         io_out <= 1'b0;
         io_oe <= 1'b0;
         done <= 1'b0;
         rd_bit <= 1'b0;
      end else begin
         cnt <= next_cnt;
         busy <= next_busy;
         ce_n <= next_ce_n;
         oe_n <= next_oe_n;
         we_n <= next_we_n;
         io_out <= next_io_out;
         io_oe <= next_io_oe;
         done <= next_done;
         rd_bit <= next_rd_bit;
      end
   end
endmodule

// ### verilog/serial_prom_host.sv
// Host controller that reads and page-writes a bit-serial bus EEPROM.
// What this block does
// - Never assert write and output enables together
// - Send 16 address bits MSB first, writes
// - Read each byte over eight read cycles
// - Precede every operation with reset sequence
// - Write: reset, address, up to 32 bytes
// - Read, write one, read starts programming
`timescale 1ns/100ps
module serial_prom_host #(
   parameter int BUSY_POLLS = serial_prom_pkg::BUSY_POLL_MAX
)(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [2:0] CMD,
   input wire logic CMD_VALID,
   input wire logic [15:0] CMD_ADDR,
   input wire logic [4:0] CMD_LEN,
   input wire logic [7:0] WR_DATA,
   input wire logic [4:0] RD_COUNT,
   input wire logic IO_IN,
   output logic CMD_READY,
   output logic WR_DATA_TAKE,
   output logic [7:0] RD_DATA,
   output logic RD_VALID,
   output logic DONE,
   output logic TIMEOUT,
   output logic CE_N,
   output logic OE_N,
   output logic WE_N,
   output logic IO_OUT,
   output logic IO_OE
);
   import serial_prom_pkg::*;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_RST_RD1 = 4'h1,
      ST_RST_WR0 = 4'h2,
      ST_RST_RD2 = 4'h3,
      ST_ADDR = 4'h4,
      ST_RDATA = 4'h5,
      ST_RSTOP = 4'h6,
      ST_WDATA = 4'h7,
      ST_GO_RD1 = 4'h8,
      ST_GO_WR1 = 4'h9,
      ST_GO_RD2 = 4'ha,
      ST_POLL = 4'hb,
      ST_FIN = 4'hc
   } state_t;

   state_t state, next_state;
   logic is_write, next_is_write;
   logic [15:0] addr_sr, next_addr_sr;
   logic [7:0] byte_sr, next_byte_sr;
   logic [4:0] bit_cnt, next_bit_cnt;
   logic [4:0] byte_cnt, next_byte_cnt;
   logic [16:0] polls, next_polls;
   logic next_cmd_ready, next_take, next_rd_valid, next_done, next_timeout;
   logic [7:0] next_rd_data;
   logic cyc_start;
   cyc_t cyc_kind;
   logic cyc_done, cyc_bit;
   logic ce_n, oe_n, we_n, io_out, io_oe;
   logic [2:0] io_meta;

   // The data pin is asynchronous to CLK; a read bit counts as high only when the last two stages are both high.
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         io_meta <= 3'h0;
      end else begin
         io_meta <= {io_meta[1:0], IO_IN};
      end
   end

   bus_cycle cyc (
      .clk(CLK),
      .rst_n(RST_N),
      .start(cyc_start),
      .kind(cyc_kind),
      .io_sync(io_meta[2] & io_meta[1]),
      .ce_n(ce_n),
      .oe_n(oe_n),
      .we_n(we_n),
      .io_out(io_out),
      .io_oe(io_oe),
      .done(cyc_done),
      .rd_bit(cyc_bit)
   );

   always_comb begin
      next_state = state;
      next_is_write = is_write;
      next_addr_sr = addr_sr;
      next_byte_sr = byte_sr;
      next_bit_cnt = bit_cnt;
      next_byte_cnt = byte_cnt;
      next_polls = polls;
      next_cmd_ready = 1'b0;
      next_take = 1'b0;
      next_rd_valid = 1'b0;
      next_rd_data = RD_DATA;
      next_done = 1'b0;
      next_timeout = TIMEOUT;
      cyc_start = 1'b0;
      cyc_kind = CYC_RD;
      case (state)
         ST_IDLE: begin
            // Select stays high between operations, so the bus is free meanwhile.
            next_cmd_ready = 1'b1;
            if (CMD_VALID && CMD_READY && (CMD == CMD_READ || CMD == CMD_WRITE)) begin
               next_cmd_ready = 1'b0;
               next_is_write = (CMD == CMD_WRITE);
               next_addr_sr = CMD_ADDR;
               next_byte_cnt = (CMD == CMD_WRITE) ? CMD_LEN : RD_COUNT;
               next_bit_cnt = CNT_ZERO;
               next_timeout = 1'b0;
               next_state = ST_RST_RD1;
            end
         end
         ST_RST_RD1, ST_GO_RD1: begin
            cyc_start = 1'b1;
            if (cyc_done) begin
               next_state = (state == ST_RST_RD1) ? ST_RST_WR0 : ST_GO_WR1;
            end
         end
         ST_RST_WR0: begin
            cyc_start = 1'b1;
            cyc_kind = CYC_WR0;
            if (cyc_done) begin
               next_state = ST_RST_RD2;
            end
         end
         ST_RST_RD2: begin
            cyc_start = 1'b1;
            if (cyc_done) begin
               next_state = ST_ADDR;
            end
         end
         ST_ADDR: begin
            cyc_start = 1'b1;
            cyc_kind = addr_sr[15] ? CYC_WR1 : CYC_WR0;
            if (cyc_done) begin
               next_addr_sr = {addr_sr[14:0], 1'b0};
               next_bit_cnt = bit_cnt + 5'h01;
               if (bit_cnt == ADDR_LAST) begin
                  next_bit_cnt = CNT_ZERO;
                  next_byte_sr = WR_DATA;
                  next_take = is_write;
                  next_state = is_write ? ST_WDATA : ST_RDATA;
               end
            end
         end
         ST_RDATA: begin
            cyc_start = 1'b1;
            if (cyc_done) begin
               next_byte_sr = {byte_sr[6:0], cyc_bit};
               next_bit_cnt = bit_cnt + 5'h01;
               if (bit_cnt == BIT_LAST) begin
                  // Device advances its own address, wrapping at the top.
                  next_rd_data = {byte_sr[6:0], cyc_bit};
                  next_rd_valid = 1'b1;
                  next_bit_cnt = CNT_ZERO;
                  next_byte_cnt = byte_cnt - 5'h01;
                  if (byte_cnt == CNT_ZERO) begin
                     next_state = ST_RSTOP;
                  end
               end
            end
         end
         ST_RSTOP: begin
            cyc_start = 1'b1;
            cyc_kind = CYC_WR1;
            if (cyc_done) begin
               next_state = ST_FIN;
            end
         end
         ST_WDATA: begin
            cyc_start = 1'b1;
            cyc_kind = byte_sr[7] ? CYC_WR1 : CYC_WR0;
            if (cyc_done) begin
               next_byte_sr = {byte_sr[6:0], 1'b0};
               next_bit_cnt = bit_cnt + 5'h01;
               if (bit_cnt == BIT_LAST) begin
                  next_bit_cnt = CNT_ZERO;
                  next_byte_cnt = byte_cnt - 5'h01;
                  // Whole bytes only and at most a page; a write that starts mid-page wraps to the page start.
                  if (byte_cnt == CNT_ZERO) begin
                     next_state = ST_GO_RD1;
                  end else begin
                     next_byte_sr = WR_DATA;
                     next_take = 1'b1;
                  end
               end
            end
         end
         ST_GO_WR1: begin
            cyc_start = 1'b1;
            cyc_kind = CYC_WR1;
            if (cyc_done) begin
               next_state = ST_GO_RD2;
            end
         end
         ST_GO_RD2: begin
            cyc_start = 1'b1;
            if (cyc_done) begin
               next_polls = 17'h00000;
               next_state = ST_POLL;
            end
         end
         ST_POLL: begin
            // Low means busy; with protect low the device never starts and reads high.
            cyc_start = 1'b1;
            if (cyc_done) begin
               next_polls = polls + 17'h00001;
               if (cyc_bit) begin
                  next_state = ST_FIN;
               end else if (polls == 17'(BUSY_POLLS)) begin
                  next_timeout = 1'b1;
                  next_state = ST_FIN;
               end
            end
         end
         ST_FIN: begin
            next_done = 1'b1;
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state <= ST_IDLE;
         is_write <= 1'b0;
         addr_sr <= 16'h0000;
         byte_sr <= 8'h00;
         bit_cnt <= 5'h00;
         byte_cnt <= 5'h00;
         polls <= 17'h00000;
         CMD_READY <= 1'b0;
         WR_DATA_TAKE <= 1'b0;
         RD_VALID <= 1'b0;
         RD_DATA <= 8'h00;
         DONE <= 1'b0;
         TIMEOUT <= 1'b0;
      end else begin
         state <= next_state;
         is_write <= next_is_write;
         addr_sr <= next_addr_sr;
         byte_sr <= next_byte_sr;
         bit_cnt <= next_bit_cnt;
         byte_cnt <= next_byte_cnt;
         polls <= next_polls;
         CMD_READY <= next_cmd_ready;
         WR_DATA_TAKE <= next_take;
         RD_VALID <= next_rd_valid;
         RD_DATA <= next_rd_data;
         DONE <= next_done;
         TIMEOUT <= next_timeout;
      end
   end

   // Pin drivers come straight from the cycle module's flip-flops.
   assign CE_N = ce_n;
   assign OE_N = oe_n;
   assign WE_N = we_n;
   assign IO_OUT = io_out;
   assign IO_OE = io_oe;
endmodule

// ### sim/serial_prom_host_checker.sv
// Strobe and handshake assertions for the serial EEPROM host.
`timescale 1ns/100ps
module serial_prom_host_checker (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CMD_READY,
   input wire logic RD_VALID,
   input wire logic WR_DATA_TAKE,
   input wire logic DONE,
   input wire logic CE_N,
   input wire logic OE_N,
   input wire logic WE_N,
   input wire logic IO_OE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   property p_excl; !CE_N |-> (OE_N || WE_N); endproperty
   a_excl: assert property (p_excl) else $error("both enables low");
   property p_idle; CE_N |-> (OE_N && WE_N); endproperty
   a_idle: assert property (p_idle) else $error("strobe without select");
   property p_rdz; !OE_N |-> !IO_OE; endproperty
   a_rdz: assert property (p_rdz) else $error("host drives during read");
   property p_wrd; !WE_N |-> IO_OE; endproperty
   a_wrd: assert property (p_wrd) else $error("write without data");
   property p_hold; $rose(CE_N) && !$past(WE_N) |-> IO_OE; endproperty
   a_hold: assert property (p_hold) else $error("data hold lost");
   property p_width; $fell(CE_N) && !WE_N |-> (!CE_N) [*3] ##1 CE_N; endproperty
   a_width: assert property (p_width) else $error("write strobe width wrong");
   // Reads stay low one cycle longer so the returned bit clears the synchroniser.
   property p_rwidth; $fell(CE_N) && !OE_N |-> (!CE_N) [*4] ##1 CE_N; endproperty
   a_rwidth: assert property (p_rwidth) else $error("read strobe width wrong");
   property p_gap; $rose(CE_N) |-> CE_N ##1 CE_N; endproperty
   a_gap: assert property (p_gap) else $error("strobes too close");
   property p_first; $fell(CMD_READY) |-> CE_N ##1 (!CE_N && !OE_N && WE_N); endproperty
   a_first: assert property (p_first) else $error("operation not opened by read");
   property p_rest; CMD_READY |-> CE_N; endproperty
   a_rest: assert property (p_rest) else $error("select low while idle");
   c_rd: cover property (RD_VALID);
   c_wr: cover property (WR_DATA_TAKE);
   c_done: cover property (DONE);
endmodule
bind serial_prom_host serial_prom_host_checker u_serial_prom_host_checker (.CLK(CLK),
   .RST_N(RST_N), .CMD_READY(CMD_READY), .RD_VALID(RD_VALID), .WR_DATA_TAKE(WR_DATA_TAKE),
   .DONE(DONE), .CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N), .IO_OE(IO_OE));

// ### sim/prom_model.sv
// Behavioural bit-serial EEPROM answering the host's strobe cycles.
`timescale 1ns/100ps
module prom_model #(
   parameter int PROG_NS = 1500
)(
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic wp_n,
   input wire logic pin,
   output logic q
);
   logic [7:0] mem [0:65535];
   logic [7:0] page [0:31];
   logic [31:0] ld;
   logic [15:0] a;
   logic [10:0] base;
   logic [7:0] sh;
   logic b, busy, wel, last, dq;
   int st, nb, nl, kind, prev;
   // A released pin shows the inverse of its last value, so no stale bit passes.
   assign q = (!ce_n && !oe_n) ? dq : ~last;
   assign dq = busy ? 1'b0 : (st == 2 || st == 3) ? mem[a][3'(7 - nb)] : 1'b1;
   initial begin
      {busy, last, st, kind, prev} = 0;
      wel = 0;
      for (int i = 0; i < 65536; i++) begin
         mem[i] = 8'(i ^ (i >> 8));
      end
   end
   always @(negedge wp_n) wel = 0;
   always @(posedge busy) begin
      #(PROG_NS);
      for (int i = 0; i < 32; i++) begin
         if (ld[i]) mem[{base, 5'(i)}] = page[i];
      end
      busy = 0;
      wel = 0;
      st = 0;
   end
   // Purely event driven, so any pause between cycles is harmless.
   always @(ce_n, oe_n, we_n, pin) begin
      if (!ce_n && !we_n) begin
         kind = 1;
         b = pin;
      end else if (!ce_n && !oe_n) begin
         kind = 2;
         last = dq;
      end
      if (kind != 0 && (ce_n || (kind == 1 && we_n))) begin
         step();
         prev = kind;
         kind = 0;
      end
   end
   task automatic step();
      bit head;
      // The first address bit follows the reset's closing read and is not a new sequence.
      head = (st == 1 && nb == 0);
      if (kind == 2) begin
         if (st == 2 || st == 3) begin
            st = 3;
            nb++;
            if (nb == 8) begin
               nb = 0;
               a++;
            end
         end else if (st == 7) st = 1;
         else if (st == 4) st = 5;
         else if (st == 6 && wel && wp_n && nl % 8 == 0 && !busy) begin
            base = a[15:5];
            busy = 1;
         end else if (st >= 5) {st, wel} = 0;
      end else if (prev == 2 && !b && !head) begin
         if (!busy) begin
            {st, nb, nl, ld} = {32'd7, 96'd0};
            wel = wp_n;
         end
      end else if (prev == 2 && st == 5) st = 6;
      else if ((prev == 2 && !head) || st == 7 || st == 3 || st == 0) {st, wel} = 0;
      else if (st == 1) begin
         a = {a[14:0], b};
         nb++;
         if (nb == 16) {st, nb} = {32'd2, 32'd0};
      end else begin
         st = 4;
         sh = {sh[6:0], b};
         nl++;
         if (nl % 8 == 0) begin
            page[a[4:0]] = sh;
            ld[a[4:0]] = 1'b1;
            a[4:0] = a[4:0] + 5'h01;
         end
      end
   endtask
endmodule

// ### sim/serial_prom_host_tb.sv
// Self-checking bench: host against the behavioural EEPROM and a reference memory.
`timescale 1ns/100ps
module serial_prom_host_tb;
   import serial_prom_pkg::*;
   logic CLK, RST_N, CMD_VALID, IO_IN, wp_n, q;
   logic [2:0] CMD;
   logic [15:0] CMD_ADDR, ad;
   logic [4:0] CMD_LEN, RD_COUNT;
   logic [7:0] WR_DATA, RD_DATA, d;
   logic CMD_READY, WR_DATA_TAKE, RD_VALID, DONE, TIMEOUT, CE_N, OE_N, WE_N, IO_OUT, IO_OE;
   logic [7:0] ref_mem [0:65535];
   logic [7:0] wq [$];
   int bad_count, check_count, n;
   assign IO_IN = IO_OE ? IO_OUT : q;
   serial_prom_host #(.BUSY_POLLS(20)) u_serial_prom_host (.CLK(CLK), .RST_N(RST_N),
      .CMD(CMD), .CMD_VALID(CMD_VALID), .CMD_ADDR(CMD_ADDR), .CMD_LEN(CMD_LEN),
      .WR_DATA(WR_DATA), .RD_COUNT(RD_COUNT), .IO_IN(IO_IN), .CMD_READY(CMD_READY),
      .WR_DATA_TAKE(WR_DATA_TAKE), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .DONE(DONE),
      .TIMEOUT(TIMEOUT), .CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N), .IO_OUT(IO_OUT), .IO_OE(IO_OE));
   prom_model u_prom_model (.ce_n(CE_N), .oe_n(OE_N), .we_n(WE_N), .wp_n(wp_n), .pin(IO_IN),
      .q(q));
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] want);
      check_count++;
      if (seen !== want) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, want, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic op(input logic [2:0] c, input logic [15:0] a, input int len);
      int t, k;
      {t, k} = 0;
      do begin
         @(negedge CLK);
         t++;
      end while (CMD_READY !== 1'b1 && t < 100);
      {CMD, CMD_ADDR, CMD_LEN, RD_COUNT} = {c, a, 5'(len - 1), 5'(len - 1)};
      if (wq.size() > 0) WR_DATA = wq.pop_front();
      CMD_VALID = 1'b1;
      @(negedge CLK);
      CMD_VALID = 1'b0;
      do begin
         @(negedge CLK);
         t++;
         if (WR_DATA_TAKE === 1'b1 && wq.size() > 0) WR_DATA = wq.pop_front();
         if (RD_VALID === 1'b1) begin
            chk("rd_data", RD_DATA, ref_mem[16'(a + k)]);
            k++;
         end
      end while (DONE !== 1'b1 && t < 20000);
      if (t >= 20000) begin
         bad_count++;
         tally_and_finish();
      end
      chk("bytes", 16'(k), (c == CMD_READ) ? 16'(len) : 16'h0000);
      chk("timeout", TIMEOUT, 16'h0000);
   endtask
   initial begin
      CLK = 0;
      forever #20 CLK = ~CLK;
   end
   initial begin
      {RST_N, CMD_VALID, CMD, CMD_ADDR, CMD_LEN, RD_COUNT, WR_DATA} = 0;
      wp_n = 1'b1;
      check_count = 0;
      bad_count = 0;
      for (int i = 0; i < 65536; i++) ref_mem[i] = 8'(i ^ (i >> 8));
      void'($urandom(32'h7251));
      repeat (20) @(negedge CLK);
      RST_N = 1;
      // An undefined command must leave the host idle with select high.
      CMD = 3'h3;
      CMD_VALID = 1'b1;
      repeat (3) @(negedge CLK);
      chk("bad_cmd", 16'({CE_N, CMD_READY}), 16'h0003);
      CMD_VALID = 1'b0;
      $display("test bad_cmd done");
      op(CMD_READ, 16'hfffe, 4);
      $display("test read_wrap done");
      for (int j = 0; j < 3; j++) begin
         wp_n = (j != 2);
         ad = 16'($urandom());
         n = (j == 0) ? 32 : 1 + $urandom_range(30);
         for (int i = 0; i < n; i++) begin
            d = 8'($urandom());
            wq.push_back(d);
            if (wp_n) ref_mem[{ad[15:5], 5'(ad[4:0] + i)}] = d;
         end
         op(CMD_WRITE, ad, n);
         op(CMD_READ, {ad[15:5], 5'h00}, 32);
         $display("test write %0d done", j);
      end
      tally_and_finish();
   end
endmodule
